/* logic/apc_pkg.sv */
// Constants and types of the adaptive pixel clock and fixed-geometry frame output stage.
// Assumes a 32-bit AXI4-Lite register bus and one system clock.
package apc_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [7:0]  REG_CTRL_IDX    = 8'h0d;
  localparam logic [7:0]  REG_CLK12_IDX   = 8'h0e;
  localparam logic [7:0]  REG_CLK3_IDX    = 8'h0f;
  localparam logic [7:0]  REG_WIDTH_IDX   = 8'h10;
  localparam logic [7:0]  REG_HEIGHT_IDX  = 8'h11;
  localparam logic [7:0]  REG_STATUS_IDX  = 8'h13;
  // Reset values
  localparam logic [15:0] CTRL_RST        = 16'h0000;
  localparam logic [15:0] CLK12_RST       = 16'h0501;
  localparam logic [7:0]  CLK3_RST        = 8'h03;
  localparam logic [11:0] WIDTH_RST       = 12'h640;
  localparam logic [11:0] HEIGHT_RST      = 12'h258;
  // Field positions
  localparam int          DIV1_LSB        = 0;
  localparam int          SLEW1_LSB       = 5;
  localparam int          DIV2_LSB        = 8;
  localparam int          SLEW2_LSB       = 13;
  localparam int          DIV3_LSB        = 0;
  localparam int          SLEW3_LSB       = 5;
  localparam int          CTRL_FRAME_EN   = 0;
  localparam int          CTRL_IGN_HEIGHT = 5;
  localparam int          CTRL_ADAPTIVE   = 6;
  localparam int          CTRL_FREEZE     = 11;
  // Occupancy thresholds in quarters of buffer depth
  localparam int          Q_UP2           = 2;
  localparam int          Q_UP3           = 3;
  localparam int          Q_DN2           = 2;
  localparam int          Q_DN1           = 1;
  // Idle pixel clocks between two lines
  localparam logic [7:0]  LINE_GAP_CLKS   = 8'h06;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  typedef enum logic [1:0] {SRC_FIRST, SRC_SECOND, SRC_THIRD} apc_src_type;
  typedef enum logic [1:0] {FR_IDLE, FR_LINE, FR_GAP} apc_frame_type;
endpackage

/* logic/apc_top.sv */
// Adaptive pixel clock generator and fixed-geometry frame sequencer with an AXI4-Lite slave.
// Assumes buffer occupancy, pixel data and blanking strobes come from logic on SYS_CLK.
//
// Summary of operation
// - The first clock source divides the clock by divisor field 3:0 of register 0x0e, reset 1.
// - The second clock source divides by divisor field 11:8 of register 0x0e, reset 5.
// - The third clock source divides by divisor field 3:0 of register 0x0f, reset 3.
// - A divisor programmed as zero acts exactly as a divisor of one.
// - With adaptive clocking on, the first source gives way to the second at half occupancy.
// - With adaptive clocking on, the second gives way to the third at three quarters occupancy.
// - The slew output carries the slew field of the source now driving the pixel clock.
// - The line qualifier stays high for the number of pixel clocks in the width field.
// - A frame holds as many line qualifier pulses as the height field gives.
// - The height field is disregarded while the ignore-height control bit 5 is set.
// - Occupancy-driven switching happens only while adaptive enable bit 6 is set.
// - Falling occupancy steps third to second below half, second to first below a quarter.
// - Every frame begins on the first clock source.
// - Clock and geometry settings are copied to shadows at input blanking end unless frozen.
`timescale 1ns/1ps
module apc_top
#(
  parameter int LW    = 11,
  parameter int DEPTH = 1024
) (
  input  wire logic              SYS_CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  input  wire logic [LW-1:0]     FIFO_LEVEL,
  input  wire logic              VBLANK_END,
  input  wire logic              FRAME_REQ,
  input  wire logic              DATA_DONE,
  input  wire logic [7:0]        PIX_DATA_IN,
  input  wire logic              PIX_VALID_IN,
  output logic                   PIX_POP,
  output logic                   PIXEL_CLK_OUT,
  output logic                   LINE_VALID_OUT,
  output logic                   FRAME_VALID_OUT,
  output logic [7:0]             PIX_DATA_OUT,
  output logic [2:0]             SLEW_OUT
);
  import apc_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [3:0] div_fix(input logic [3:0] n);
    div_fix = (n == 4'h0) ? 4'h1 : n;
  endfunction

  function automatic logic at_least(input logic [LW-1:0] lvl, input int quarters);
    at_least = (32'(lvl) * 4) >= (32'(DEPTH) * quarters);
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
    hit = (a[7:2] == idx[5:0]);
  endfunction

  // ------------------------------------------------------------------
  // Registers and shadows
  // ------------------------------------------------------------------
  logic [15:0]   ctrl_q, clk12_q, sh_clk12_q;
  logic [7:0]    clk3_q, sh_clk3_q;
  logic [11:0]   width_q, height_q, sh_width_q, sh_height_q;
  logic [7:0]    aw_q;
  logic [31:0]   wd_q;
  logic [3:0]    ws_q;
  logic          aw_have_q, w_have_q;
  apc_src_type   src_q;
  apc_frame_type fr_q;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ------------------------------------------------------------------
  // AXI4-Lite write channel
  // ------------------------------------------------------------------
  logic          wr_fire;
  assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_have_q && !S_AXI_BVALID;
  assign wr_fire       = aw_have_q && w_have_q && !S_AXI_BVALID;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_q         <= 8'h00;
      wd_q         <= 32'h0000_0000;
      ws_q         <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_q      <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wd_q     <= S_AXI_WDATA;
        ws_q     <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (hit(aw_q, REG_CTRL_IDX) || hit(aw_q, REG_CLK12_IDX) ||
                         hit(aw_q, REG_CLK3_IDX) || hit(aw_q, REG_WIDTH_IDX) ||
                         hit(aw_q, REG_HEIGHT_IDX)) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ctrl_q   <= CTRL_RST;
      clk12_q  <= CLK12_RST;
      clk3_q   <= CLK3_RST;
      width_q  <= WIDTH_RST;
      height_q <= HEIGHT_RST;
    end else if (wr_fire) begin
      if (hit(aw_q, REG_CTRL_IDX))   ctrl_q   <= merge(ctrl_q, wd_q, ws_q);
      if (hit(aw_q, REG_CLK12_IDX))  clk12_q  <= merge(clk12_q, wd_q, ws_q) & 16'hefef;
      if (hit(aw_q, REG_CLK3_IDX))   clk3_q   <= ws_q[0] ? (wd_q[7:0] & 8'hef) : clk3_q;
      if (hit(aw_q, REG_WIDTH_IDX))  width_q  <= 12'(merge({4'h0, width_q}, wd_q, ws_q));
      if (hit(aw_q, REG_HEIGHT_IDX)) height_q <= 12'(merge({4'h0, height_q}, wd_q, ws_q));
    end
  end

  // Working copies keep a running frame consistent while software reprograms
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sh_clk12_q  <= CLK12_RST;
      sh_clk3_q   <= CLK3_RST;
      sh_width_q  <= WIDTH_RST;
      sh_height_q <= HEIGHT_RST;
    end else if (VBLANK_END && !ctrl_q[CTRL_FREEZE]) begin
      sh_clk12_q  <= clk12_q;
      sh_clk3_q   <= clk3_q;
      sh_width_q  <= width_q;
      sh_height_q <= height_q;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite read channel
  // ------------------------------------------------------------------
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= RESP_OKAY;
      if (hit(S_AXI_ARADDR, REG_CTRL_IDX))        S_AXI_RDATA <= {16'h0000, ctrl_q};
      else if (hit(S_AXI_ARADDR, REG_CLK12_IDX))  S_AXI_RDATA <= {16'h0000, clk12_q};
      else if (hit(S_AXI_ARADDR, REG_CLK3_IDX))   S_AXI_RDATA <= {24'h000000, clk3_q};
      else if (hit(S_AXI_ARADDR, REG_WIDTH_IDX))  S_AXI_RDATA <= {20'h00000, width_q};
      else if (hit(S_AXI_ARADDR, REG_HEIGHT_IDX)) S_AXI_RDATA <= {20'h00000, height_q};
      else if (hit(S_AXI_ARADDR, REG_STATUS_IDX))
        S_AXI_RDATA <= {26'h0000000, fr_q, 2'(src_q), FRAME_VALID_OUT, LINE_VALID_OUT};
      else begin
        S_AXI_RDATA <= 32'h0000_0000;
        S_AXI_RRESP <= RESP_SLVERR;
      end
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Pixel clock divider and source selection
  // ------------------------------------------------------------------
  // Each half period lasts N system clocks; a new source is taken only when a
  // low half ends, so both halves of every period are whole.
  logic [3:0]  n_q, cnt_q;
  logic        half_end, rise_pt, fall_pt, go_q, req_q;
  apc_src_type src_d;

  assign half_end = (cnt_q == n_q - 4'h1);
  assign rise_pt  = half_end && !PIXEL_CLK_OUT;
  assign fall_pt  = half_end && PIXEL_CLK_OUT;

  function automatic logic [3:0] div_of(input apc_src_type s, input logic [15:0] c12,
                                        input logic [7:0] c3);
    case (s)
      SRC_SECOND: div_of = div_fix(c12[DIV2_LSB +: 4]);
      SRC_THIRD:  div_of = div_fix(c3[DIV3_LSB +: 4]);
      default:    div_of = div_fix(c12[DIV1_LSB +: 4]);
    endcase
  endfunction

  always_comb begin
    src_d = src_q;
    if (!ctrl_q[CTRL_ADAPTIVE] || (req_q && fr_q == FR_IDLE && !go_q)) begin
      src_d = SRC_FIRST;
    end else begin
      case (src_q)
        SRC_FIRST:  if (at_least(FIFO_LEVEL, Q_UP2)) src_d = SRC_SECOND;
        SRC_SECOND: begin
          if (at_least(FIFO_LEVEL, Q_UP3)) src_d = SRC_THIRD;
          else if (!at_least(FIFO_LEVEL, Q_DN1)) src_d = SRC_FIRST;
        end
        SRC_THIRD:  if (!at_least(FIFO_LEVEL, Q_DN2)) src_d = SRC_SECOND;
        default:    src_d = SRC_FIRST;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      cnt_q         <= 4'h0;
      n_q           <= 4'h1;
      src_q         <= SRC_FIRST;
      PIXEL_CLK_OUT <= 1'b0;
    end else if (half_end) begin
      cnt_q         <= 4'h0;
      PIXEL_CLK_OUT <= !PIXEL_CLK_OUT;
      if (rise_pt) begin
        src_q <= src_d;
        n_q   <= div_of(src_d, sh_clk12_q, sh_clk3_q);
      end
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  always_comb begin
    case (src_q)
      SRC_SECOND: SLEW_OUT = sh_clk12_q[SLEW2_LSB +: 3];
      SRC_THIRD:  SLEW_OUT = sh_clk3_q[SLEW3_LSB +: 3];
      default:    SLEW_OUT = sh_clk12_q[SLEW1_LSB +: 3];
    endcase
  end

  // ------------------------------------------------------------------
  // Frame sequencer, stepped at pixel clock falls so the host samples
  // stable qualifiers at the rise
  // ------------------------------------------------------------------
  logic [11:0] pix_q, line_q, w_eff;
  logic [7:0]  gap_q;
  logic        done_q, load_pix, line_end, frame_end;

  assign w_eff     = (sh_width_q == 12'h000) ? 12'h001 : sh_width_q;
  assign line_end  = (fr_q == FR_LINE) && (pix_q == w_eff);
  assign frame_end = ctrl_q[CTRL_IGN_HEIGHT] ? (done_q || DATA_DONE)
                                             : (line_q >= sh_height_q);
  assign load_pix  = fall_pt && ((fr_q == FR_IDLE && go_q) ||
                                 (fr_q == FR_LINE && !line_end) ||
                                 (fr_q == FR_GAP && gap_q == LINE_GAP_CLKS));
  assign PIX_POP   = load_pix && PIX_VALID_IN;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      req_q <= 1'b0;
      go_q  <= 1'b0;
    end else begin
      if (FRAME_REQ && ctrl_q[CTRL_FRAME_EN]) req_q <= 1'b1;
      else if (rise_pt && fr_q == FR_IDLE && req_q) req_q <= 1'b0;
      if (rise_pt && fr_q == FR_IDLE && req_q) go_q <= 1'b1;
      else if (fall_pt) go_q <= 1'b0;
    end
  end

  // Exhausted-data mark set wins over the clear at frame start
  always_ff @(posedge SYS_CLK) begin
    if (RESET) done_q <= 1'b0;
    else if (DATA_DONE) done_q <= 1'b1;
    else if (fall_pt && fr_q == FR_IDLE && go_q) done_q <= 1'b0;
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      fr_q            <= FR_IDLE;
      pix_q           <= 12'h000;
      line_q          <= 12'h000;
      gap_q           <= 8'h00;
      LINE_VALID_OUT  <= 1'b0;
      FRAME_VALID_OUT <= 1'b0;
      PIX_DATA_OUT    <= 8'h00;
    end else if (fall_pt) begin
      PIX_DATA_OUT <= (load_pix && PIX_VALID_IN) ? PIX_DATA_IN : 8'h00;
      case (fr_q)
        FR_IDLE: if (go_q) begin
          fr_q            <= FR_LINE;
          FRAME_VALID_OUT <= 1'b1;
          LINE_VALID_OUT  <= 1'b1;
          pix_q           <= 12'h001;
          line_q          <= 12'h001;
        end
        FR_LINE: begin
          if (line_end) begin
            LINE_VALID_OUT <= 1'b0;
            gap_q          <= 8'h01;
            if (frame_end) begin
              fr_q            <= FR_IDLE;
              FRAME_VALID_OUT <= 1'b0;
            end else begin
              fr_q <= FR_GAP;
            end
          end else begin
            pix_q <= pix_q + 12'h001;
          end
        end
        FR_GAP: begin
          if (gap_q == LINE_GAP_CLKS) begin
            fr_q           <= FR_LINE;
            LINE_VALID_OUT <= 1'b1;
            pix_q          <= 12'h001;
            line_q         <= line_q + 12'h001;
          end else begin
            gap_q <= gap_q + 8'h01;
          end
        end
        default: fr_q <= FR_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic [11:0] lv_len_q;
  always_ff @(posedge SYS_CLK) begin
    if (RESET) lv_len_q <= 12'h000;
    else if (fall_pt) lv_len_q <= LINE_VALID_OUT ? lv_len_q + 12'h001 : 12'h000;
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  a_first_divisor: assert property (rise_pt && src_d == SRC_FIRST |=>
    n_q == div_fix($past(sh_clk12_q[3:0]))) else $error("first divisor wrong");
  a_second_divisor: assert property (rise_pt && src_d == SRC_SECOND |=>
    n_q == div_fix($past(sh_clk12_q[11:8]))) else $error("second divisor wrong");
  a_third_divisor: assert property (rise_pt && src_d == SRC_THIRD |=>
    n_q == div_fix($past(sh_clk3_q[3:0]))) else $error("third divisor wrong");
  a_zero_divisor: assert property (n_q != 4'h0) else $error("divisor zero used");
  a_step_up_two: assert property (rise_pt && ctrl_q[6] && src_q == SRC_FIRST && !req_q &&
    32'(FIFO_LEVEL) * 2 >= 32'(DEPTH) |=> src_q == SRC_SECOND) else $error("no step to second");
  a_step_up_three: assert property (rise_pt && ctrl_q[6] && src_q == SRC_SECOND && !req_q &&
    32'(FIFO_LEVEL) * 4 >= 32'(DEPTH) * 3 |=> src_q == SRC_THIRD) else $error("no step to third");
  a_adaptive_off: assert property (rise_pt && !ctrl_q[6] |=> src_q == SRC_FIRST)
    else $error("switched while adaptive off");
  a_step_down: assert property (rise_pt && ctrl_q[6] && src_q == SRC_THIRD && !req_q &&
    32'(FIFO_LEVEL) * 2 < 32'(DEPTH) |=> src_q == SRC_SECOND) else $error("no step down");
  a_frame_first: assert property ($rose(FRAME_VALID_OUT) |-> src_q == SRC_FIRST)
    else $error("frame not on first source");
  a_line_length: assert property ($fell(LINE_VALID_OUT) |-> lv_len_q == w_eff)
    else $error("line length wrong");
  a_shadow_copy: assert property (VBLANK_END && !ctrl_q[11] |=>
    sh_width_q == $past(width_q)) else $error("shadow not updated");
  a_slew_select: assert property (src_q == SRC_SECOND |-> SLEW_OUT == sh_clk12_q[15:13])
    else $error("slew mismatch");
  a_whole_halves: assert property (
    $changed(PIXEL_CLK_OUT) |-> $past(cnt_q) == $past(n_q) - 4'h1)
    else $error("short clock pulse");

  c_frame_done: cover property ($fell(FRAME_VALID_OUT));
  c_third_src: cover property (src_q == SRC_THIRD);
  c_ign_height: cover property ($fell(FRAME_VALID_OUT) && ctrl_q[5]);
  c_axi_write: cover property (wr_fire);
endmodule

/* verification/apc_host_cap.sv */
// Host capture port model: times the pixel clock and counts qualifiers as a receiver would.
// Assumes every pixel output is registered on the same system clock as the model.
`timescale 1ns/1ps
module apc_host_cap (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        pixel_clk,
  input  wire logic        line_valid,
  input  wire logic        frame_valid,
  input  wire logic [2:0]  slew,
  output logic      [2:0]  meas_v,
  output logic      [10:0] half_m,
  output logic      [11:0] wid_m,
  output logic      [11:0] lines_m
);
  logic        pc_q;
  logic        lv_q;
  logic        fv_q;
  logic [7:0]  hi_q;
  logic [11:0] wid_q;
  logic [11:0] ln_q;
  // --------------------------------------------------------------
  // Qualifiers sampled at pixel clock rise, as the host does; high time reported at the fall
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    pc_q <= pixel_clk;
    meas_v <= 3'b000;
    if (reset) begin
      hi_q <= 8'h00;
      lv_q <= 1'b0;
      fv_q <= 1'b0;
    end else begin
      if (pixel_clk) hi_q <= pc_q ? hi_q + 8'h01 : 8'h01;
      if (pc_q && !pixel_clk) begin
        meas_v[0] <= 1'b1;
        half_m <= {slew, hi_q};
      end
      if (!pc_q && pixel_clk) begin
        lv_q <= line_valid;
        fv_q <= frame_valid;
        if (line_valid) wid_q <= lv_q ? wid_q + 12'h001 : 12'h001;
        if (line_valid && !lv_q) ln_q <= fv_q ? ln_q + 12'h001 : 12'h001;
        if (lv_q && !line_valid) begin
          meas_v[1] <= 1'b1;
          wid_m <= wid_q;
        end
        if (fv_q && !frame_valid) begin
          meas_v[2] <= 1'b1;
          lines_m <= ln_q;
        end
      end
    end
  end
endmodule

/* verification/apc_top_tb_top.sv */
// Self-checking bench: AXI4-Lite master, pixel source and a queue of expected results.
// Assumes the host capture model reports pixel clock high time, line width and line count.
`timescale 1ns/1ps
module apc_top_tb_top;
  import apc_pkg::*;
  typedef struct {logic [1:0] k; string n; logic [33:0] v;} apc_note_type;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [7:0]  pix = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        vbe = 1'b0, freq = 1'b0, done = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [10:0] level = 11'h000;
  logic [31:0] seed = 32'h9160;
  logic        awready, wready, bvalid, arready, rvalid, pclk, lv, fv;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  slew, mv;
  logic [10:0] half_m;
  logic [11:0] wid_m, lines_m;
  int          miscompares = 0;
  int          num_checks = 0;
  apc_note_type q[$];
  logic [7:0]  pdo, pix_held;
  logic        pop;
  logic        pop_seen = 1'b0;
  int          pops = 0;

  always #5 clk = ~clk;

  apc_top i_apc_top (.SYS_CLK(clk), .RESET(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .FIFO_LEVEL(level), .VBLANK_END(vbe), .FRAME_REQ(freq), .DATA_DONE(done),
    .PIX_DATA_IN(pix), .PIX_VALID_IN(1'b1), .PIX_POP(pop), .PIXEL_CLK_OUT(pclk),
    .LINE_VALID_OUT(lv), .FRAME_VALID_OUT(fv), .PIX_DATA_OUT(pdo), .SLEW_OUT(slew));

  apc_host_cap i_apc_host_cap (.sys_clk(clk), .reset(rst), .pixel_clk(pclk), .line_valid(lv),
    .frame_valid(fv), .slew(slew), .meas_v(mv), .half_m(half_m), .wid_m(wid_m),
    .lines_m(lines_m));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [7:0] ba(input logic [7:0] i);
    return {i[5:0], 2'b00};
  endfunction
  always @(posedge clk) begin
    seed <= xs(seed);
    pix <= seed[7:0];
  end
  task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic note(input logic [1:0] k, input string n, input logic [33:0] v);
    q.push_back('{k, n, v});
  endtask
  task automatic drain;
    for (int i = 0; i < 5000 && q.size() != 0; i++) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = RESP_OKAY);
    logic ta, tw;
    note(2'd3, "write resp", {e, 32'h0});
    ta = 1'b0;
    tw = 1'b0;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge clk);
      ta = ta | awready;
      tw = tw | wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    do begin @(negedge clk); ta = bvalid; @(posedge clk); end while (!ta);
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input string n);
    logic t;
    note(2'd3, n, e);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(negedge clk); t = arready; @(posedge clk); end while (!t);
    arvalid <= 1'b0;
    do begin @(negedge clk); t = rvalid; @(posedge clk); end while (!t);
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic vb;
    vbe <= 1'b1;
    @(posedge clk);
    vbe <= 1'b0;
    @(posedge clk);
  endtask
  // Settle first: a source step happens only once per pixel period
  task automatic hp(input logic [2:0] s, input logic [7:0] h, input string n);
    repeat (40) @(posedge clk);
    note(2'd0, n, {23'h0, s, h});
    drain;
  endtask
  task wrap_up;
    // Results that never showed up count against the run
    miscompares += q.size();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Result watcher: oldest note against the matching result
  // --------------------------------------------------------------
  // Line end and frame end can report in one cycle, so each kind is taken once per cycle
  always @(negedge clk) begin
    logic [2:0] used;
    used = 3'b000;
    if (q.size() != 0 && q[0].k == 2'd3 && ((rvalid && rready) || (bvalid && bready))) begin
      chk(q[0].n, rvalid ? {rresp, rdata} : {bresp, 32'h0}, q[0].v);
      void'(q.pop_front());
    end
    for (int i = 0; i < 3; i++) begin
      if (q.size() != 0 && q[0].k != 2'd3 && mv[q[0].k] && !used[q[0].k]) begin
        used[q[0].k] = 1'b1;
        chk(q[0].n, (q[0].k == 2'd0) ? {23'h0, half_m} :
            (q[0].k == 2'd1) ? {22'h0, wid_m} : {22'h0, lines_m}, q[0].v);
        void'(q.pop_front());
      end
    end
  end

  // A popped byte must appear on the data output after the next edge
  always @(negedge clk) begin
    if (pop_seen) chk("pixel data", {26'h0, pdo}, {26'h0, pix_held});
    if (pop === 1'b1) pops++;
    pop_seen = (pop === 1'b1);
    pix_held = pix;
  end

  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    wrap_up;
  end

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ba(REG_CLK12_IDX), {RESP_OKAY, 16'h0, CLK12_RST}, "clk12");
    rd(ba(REG_CLK3_IDX), {RESP_OKAY, 24'h0, CLK3_RST}, "clk3");
    rd(ba(REG_WIDTH_IDX), {RESP_OKAY, 20'h0, WIDTH_RST}, "width");
    rd(ba(REG_HEIGHT_IDX), {RESP_OKAY, 20'h0, HEIGHT_RST}, "height");
    rd(8'h00, {RESP_SLVERR, 32'h0}, "unmapped");
    rd(ba(REG_STATUS_IDX), {RESP_OKAY, 32'h0}, "status");
    wr(8'h00, 32'h5, RESP_SLVERR);
    hp(3'd0, 8'd1, "reset half");
    $display("test registers done");
    // Zero divisor on the first source, distinct slews everywhere
    wr(ba(REG_CLK12_IDX), 32'h4220);
    wr(ba(REG_CLK3_IDX), 32'h64);
    wr(ba(REG_CTRL_IDX), 32'h40);
    vb;
    rd(ba(REG_CLK12_IDX), {RESP_OKAY, 32'h4220}, "clk12 back");
    hp(3'd1, 8'd1, "first");
    level <= {3'b010, seed[7:0]};
    hp(3'd2, 8'd2, "second");
    level <= {3'b011, seed[7:0]};
    hp(3'd3, 8'd4, "third");
    level <= {3'b001, seed[7:0]};
    hp(3'd2, 8'd2, "back second");
    level <= {3'b000, seed[7:0]};
    hp(3'd1, 8'd1, "back first");
    wr(ba(REG_CTRL_IDX), 32'h0);
    vb;
    level <= 11'd900;
    hp(3'd1, 8'd1, "adaptive off");
    $display("test adaptive done");
    wr(ba(REG_CTRL_IDX), 32'h800);
    wr(ba(REG_CLK12_IDX), 32'h3);
    vb;
    hp(3'd1, 8'd1, "frozen");
    wr(ba(REG_CTRL_IDX), 32'h0);
    vb;
    hp(3'd0, 8'd3, "unfrozen");
    $display("test shadow done");
    wr(ba(REG_WIDTH_IDX), 32'h4);
    wr(ba(REG_HEIGHT_IDX), 32'h3);
    wr(ba(REG_CTRL_IDX), 32'h1);
    vb;
    for (int i = 0; i < 3; i++) note(2'd1, "line width", 34'd4);
    note(2'd2, "lines", 34'd3);
    pops = 0;
    freq <= 1'b1;
    @(posedge clk);
    freq <= 1'b0;
    drain;
    chk("pops", 34'(pops), 34'd12);
    wr(ba(REG_CTRL_IDX), 32'h21);
    vb;
    note(2'd1, "done width", 34'd4);
    note(2'd2, "done lines", 34'd1);
    pops = 0;
    freq <= 1'b1;
    @(posedge clk);
    freq <= 1'b0;
    for (int i = 0; i < 2000 && fv !== 1'b1; i++) @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    drain;
    chk("done pops", 34'(pops), 34'd4);
    $display("test frames done");
    wrap_up;
  end
endmodule
